// ### shared/rlu_pkg.sv
`default_nettype none
package rlu_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_INSTR   = 8'h00;
   localparam logic [7:0] OFS_OPERAND = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_RESULT  = 8'h0C;
   localparam logic [7:0] OFS_INFO    = 8'h10;
   localparam logic [7:0] OFS_ADDR    = 8'h14;
   localparam logic [1:0] WBANK       = 2'h1;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [23:0] INSTR_RST  = 24'h000000;

   // status flag positions and info bits
   localparam int FLAG_C     = 0;
   localparam int FLAG_Z     = 1;
   localparam int FLAG_N     = 3;
   localparam int INF_DONE   = 0;
   localparam int INF_ILL    = 1;
   localparam int INF_DEST_W = 2;
   localparam int INF_MEM    = 3;
   localparam int INF_BYTE   = 4;

   // ----------------------------------------
   // opcode layout
   // ----------------------------------------
   localparam logic [7:0] OPC_FILE = 8'hD6;
   localparam logic [7:0] OPC_REG  = 8'hD2;
   localparam int POS_THRU = 15;
   localparam int POS_BYTE = 14;
   localparam int POS_DSEL = 13;
   localparam logic [3:0] WORK_ZERO = 4'h0;

   // addressing modes
   localparam logic [2:0] AM_DIR  = 3'h0;
   localparam logic [2:0] AM_PDEC = 3'h2;
   localparam logic [2:0] AM_PINC = 3'h3;
   localparam logic [2:0] AM_RDEC = 3'h4;
   localparam logic [2:0] AM_RINC = 3'h5;

   typedef struct packed {
      logic        file_form;
      logic        reg_form;
      logic        illegal;
      logic        thru;
      logic        byte_op;
      logic        dst_work;
      logic [12:0] faddr;
      logic [2:0]  qmode;
      logic [3:0]  dreg;
      logic [2:0]  pmode;
      logic [3:0]  sreg;
   } rlu_dec_t;

   typedef struct packed {
      logic             ack;
      logic [31:0]      rdata;
      logic [23:0]      instr;
      logic [15:0]      operand;
      logic [15:0]      status;
      logic [15:0]      result;
      logic [4:0]       info;
      logic [31:0]      addr;
      logic [15:0][15:0] w;
   } rlu_state_t;
endpackage
`default_nettype wire

// ### rtl/rlu_rotate_left_unit.sv
// Functional notes
// - through-carry file form shifts left one, operand msb goes to carry
// - through-carry puts the old carry into result bit 0
// - through-carry changes only N, Z and C status bits
// - no-carry puts msb into bit 0, updates N and Z only
// - file form writes default working register or back to file register
// - no-carry destination bit: 0 working register, 1 file register
// - byte bit: 0 word operation, 1 byte operation
// - default working register is working register zero
// - register form: direct, indirect, pre/post inc/dec on any of sixteen working registers
// - file through-carry opcode is 1101 0110 1, then B, D, f
// - file no-carry opcode is 1101 0110 0, then B, D, f
// - low opcode bits give the file register data address
// - one word, executes in one cycle
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rlu_rotate_left_unit
   import rlu_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic rlu_dec_t decode(input logic [23:0] ins);
      rlu_dec_t d;
      d.file_form = (ins[23:16] == OPC_FILE);
      d.reg_form  = (ins[23:16] == OPC_REG);
      d.thru      = ins[POS_THRU];
      d.byte_op   = ins[POS_BYTE];
      // destination bit polarity differs between through-carry and no-carry
      d.dst_work  = ins[POS_THRU] ? ins[POS_DSEL]
                                  : ~ins[POS_DSEL];
      d.faddr     = ins[12:0];
      d.qmode     = ins[13:11];
      d.dreg      = ins[10:7];
      d.pmode     = ins[6:4];
      d.sreg      = ins[3:0];
      d.illegal   = ~(d.file_form | d.reg_form) |
                    (d.reg_form & ((d.qmode > AM_RINC) |
                                   (d.pmode > AM_RINC)));
      return d;
   endfunction

   // returns {carry out, result}; byte form keeps the upper byte
   function automatic logic [16:0] rot_left(input logic [15:0] v,
                                            input logic        bop,
                                            input logic        thru,
                                            input logic        cin);
      logic       msb;
      logic       lsb;
      logic [15:0] r;
      msb = bop ? v[7] : v[15];
      lsb = thru ? cin : msb;
      r   = {v[14:0], lsb};
      if (bop) begin
         r = {v[15:8], v[6:0], lsb};
      end
      return {msb, r};
   endfunction

   function automatic logic [15:0] flags(input logic [15:0] sr,
                                         input logic [15:0] res,
                                         input logic        bop,
                                         input logic        thru,
                                         input logic        cout);
      logic [15:0] s;
      s = sr;
      s[FLAG_N] = bop ? res[7] : res[15];
      s[FLAG_Z] = bop ? (res[7:0] == 8'h00)
                      : (res == 16'h0000);
      if (thru) begin
         s[FLAG_C] = cout;
      end
      return s;
   endfunction

   // returns {new pointer, effective address}
   function automatic logic [31:0] walk(input logic [2:0]  m,
                                        input logic [15:0] w,
                                        input logic        bop);
      logic [15:0] st;
      st = bop ? 16'h0001 : 16'h0002;
      case (m)
         AM_PDEC: walk = {w - st, w};
         AM_PINC: walk = {w + st, w};
         AM_RDEC: walk = {w - st, w - st};
         AM_RINC: walk = {w + st, w + st};
         default: walk = {w, w};
      endcase
   endfunction

   // ----------------------------------------
   // state and bus decode
   // ----------------------------------------
   rlu_state_t  state_q;
   rlu_state_t  state_d;
   rlu_dec_t    dec;
   logic        req;
   logic        wr;
   logic        exe;
   logic [23:0] ins_new;

   // one wait state: ack is raised in the cycle after the request
   assign req     = wb_cyc_i & wb_stb_i;
   assign wr      = req & wb_we_i & state_q.ack;
   assign ins_new = 24'(merge({8'h00, state_q.instr}, wb_dat_i, wb_sel_i));
   assign exe     = wr & (wb_adr_i == OFS_INSTR);
   assign dec     = decode(ins_new);

   assign wb_ack_o = state_q.ack;
   assign wb_dat_o = state_q.rdata;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [15:0] src;
      logic [16:0] rot;
      logic [31:0] sw;
      logic [31:0] dw;
      logic [15:0] old;
      logic [15:0] res;
      logic [3:0]  di;
      src = 16'h0000;
      rot = 17'h00000;
      sw  = 32'h00000000;
      dw  = 32'h00000000;
      old = 16'h0000;
      res = 16'h0000;
      di  = WORK_ZERO;
      state_d       = state_q;
      state_d.ack   = req & ~state_q.ack;
      state_d.rdata = 32'h00000000;

      // read data is latched before ack so it comes from a flop
      if (req & ~state_q.ack & ~wb_we_i) begin
         if (wb_adr_i[7:6] == WBANK) begin
            state_d.rdata = {16'h0000, state_q.w[wb_adr_i[5:2]]};
         end else begin
            case (wb_adr_i)
               OFS_INSTR:   state_d.rdata = {8'h00, state_q.instr};
               OFS_OPERAND: state_d.rdata = {16'h0000, state_q.operand};
               OFS_STATUS:  state_d.rdata = {16'h0000, state_q.status};
               OFS_RESULT:  state_d.rdata = {16'h0000, state_q.result};
               OFS_INFO:    state_d.rdata = {27'h0000000, state_q.info};
               OFS_ADDR:    state_d.rdata = state_q.addr;
               default:     state_d.rdata = 32'h00000000;
            endcase
         end
      end

      if (wr) begin
         if (wb_adr_i[7:6] == WBANK) begin
            state_d.w[wb_adr_i[5:2]] = 16'(merge({16'h0000, state_q.w[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i));
         end else begin
            case (wb_adr_i)
               OFS_INSTR:   state_d.instr = ins_new;
               OFS_OPERAND: state_d.operand = 16'(merge({16'h0000, state_q.operand}, wb_dat_i, wb_sel_i));
               OFS_STATUS:  state_d.status = 16'(merge({16'h0000, state_q.status}, wb_dat_i, wb_sel_i));
               default: ;
            endcase
         end
      end

      // an instruction write executes at the same edge
      if (exe) begin
         state_d.info = 5'h00;
         state_d.info[INF_ILL] = dec.illegal;
         if (!dec.illegal) begin
            state_d.info[INF_DONE] = 1'b1;
            state_d.info[INF_BYTE] = dec.byte_op;
            if (dec.file_form) begin
               // file operand is fetched from f by the core
               src = state_q.operand;
               state_d.addr = {3'h0, dec.faddr, 3'h0, dec.faddr};
            end else begin
               // source pointer walk, then destination pointer walk
               sw = walk(dec.pmode, state_q.w[dec.sreg],
                         dec.byte_op);
               src = (dec.pmode == AM_DIR) ? state_q.w[dec.sreg]
                                           : state_q.operand;
               if (dec.pmode != AM_DIR) begin
                  state_d.w[dec.sreg] = sw[31:16];
               end
               dw = walk(dec.qmode, state_d.w[dec.dreg],
                         dec.byte_op);
               if (dec.qmode != AM_DIR) begin
                  state_d.w[dec.dreg] = dw[31:16];
               end
               state_d.addr = {sw[15:0], dw[15:0]};
            end
            rot = rot_left(src, dec.byte_op, dec.thru,
                           state_q.status[FLAG_C]);
            res = rot[15:0];
            state_d.status = flags(state_q.status, res, dec.byte_op,
                                   dec.thru, rot[16]);
            state_d.result = res;

            // pick the destination register, if any
            if (dec.file_form) begin
               di = WORK_ZERO;
               state_d.info[INF_DEST_W] = dec.dst_work;
               state_d.info[INF_MEM]    = ~dec.dst_work;
            end else begin
               di = dec.dreg;
               state_d.info[INF_DEST_W] = (dec.qmode == AM_DIR);
               state_d.info[INF_MEM]    = (dec.qmode != AM_DIR);
            end
            if (state_d.info[INF_DEST_W]) begin
               // a byte write leaves the register's upper byte alone
               old = state_d.w[di];
               state_d.w[di] = dec.byte_op ? {old[15:8], res[7:0]}
                                           : res;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_q         <= '0;
         state_q.instr   <= INSTR_RST;
         state_q.status  <= STATUS_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_file(logic t, logic b);
      exe && dec.file_form && !dec.illegal &&
      dec.thru == t && dec.byte_op == b;
   endsequence

   property p_thru_word;
      s_file(1'b1, 1'b0) |=>
         state_q.result == {$past(state_q.operand[14:0]),
                            $past(state_q.status[FLAG_C])} &&
         state_q.status[FLAG_C] == $past(state_q.operand[15]);
   endproperty
   a_thru_word: assert property (p_thru_word)
      else $error("rotate through carry word result wrong");

   property p_thru_byte;
      s_file(1'b1, 1'b1) |=>
         state_q.result[0] == $past(state_q.status[FLAG_C]) &&
         state_q.status[FLAG_C] == $past(state_q.operand[7]);
   endproperty
   a_thru_byte: assert property (p_thru_byte)
      else $error("old carry not in result bit 0");

   property p_thru_others;
      exe && !dec.illegal |=>
         state_q.status[15:4] == $past(state_q.status[15:4]) &&
         state_q.status[2] == $past(state_q.status[2]);
   endproperty
   a_thru_others: assert property (p_thru_others)
      else $error("status bits outside N Z C changed");

   property p_nocarry;
      s_file(1'b0, 1'b0) |=>
         state_q.status[FLAG_C] == $past(state_q.status[FLAG_C]) &&
         state_q.result[0] == $past(state_q.operand[15]);
   endproperty
   a_nocarry: assert property (p_nocarry)
      else $error("no-carry rotate wrong");

   property p_nocarry_dest;
      exe && dec.file_form && !dec.thru && !ins_new[POS_DSEL] |=>
         state_q.w[0][7:0] == state_q.result[7:0] &&
         state_q.info[INF_DEST_W];
   endproperty
   a_nocarry_dest: assert property (p_nocarry_dest)
      else $error("no-carry result missing in working register zero");

   property p_thru_file;
      exe && dec.file_form && dec.thru && !ins_new[POS_DSEL] |=>
         state_q.info[INF_MEM] &&
         state_q.addr[12:0] == $past(dec.faddr) &&
         state_q.w[0] == $past(state_q.w[0]);
   endproperty
   a_thru_file: assert property (p_thru_file)
      else $error("file destination not honoured");

   property p_byte_upper;
      exe && dec.file_form && dec.byte_op |=>
         state_q.result[15:8] == $past(state_q.operand[15:8]);
   endproperty
   a_byte_upper: assert property (p_byte_upper)
      else $error("byte operation touched upper byte");

   property p_flags;
      exe && !dec.illegal |=>
         state_q.status[FLAG_Z] == (state_q.info[INF_BYTE] ?
            (state_q.result[7:0] == 8'h00) :
            (state_q.result == 16'h0000)) &&
         state_q.status[FLAG_N] == (state_q.info[INF_BYTE] ?
            state_q.result[7] : state_q.result[15]);
   endproperty
   a_flags: assert property (p_flags)
      else $error("N or Z flag wrong");

   property p_one_cycle;
      req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("ack not a single cycle after one wait");

   property p_postinc;
      exe && dec.reg_form && !dec.illegal && !dec.byte_op &&
      dec.pmode == AM_PINC && dec.dreg != dec.sreg |=>
         state_q.w[$past(dec.sreg)] ==
            $past(state_q.w[dec.sreg]) + 16'h0002;
   endproperty
   a_postinc: assert property (p_postinc)
      else $error("source post-increment wrong");

   property p_illegal;
      exe && ins_new[23:16] != OPC_FILE &&
      ins_new[23:16] != OPC_REG |=>
         state_q.info[INF_ILL] &&
         state_q.result == $past(state_q.result);
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("foreign opcode executed");

endmodule
`default_nettype wire

// ### dv/rotate_left_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_left_unit_bench
   import rlu_pkg::*;
();
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clock;
   logic        rstn;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   int          fail_count;
   int          total_checks;
   int          seed;

   rlu_rotate_left_unit i_dut (
      .clock    (clock),
      .rstn     (rstn),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o)
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic close_out;
      if (fail_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one classic cycle; a fresh edge first keeps cyc low a cycle between requests
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                     input logic [3:0] sel, output logic [31:0] q);
      int n;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= sel;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         chk({31'h0, wb_ack_o}, 32'h1);
         close_out();
      end else begin
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i  <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, adr, d, 4'hF, q);
   endtask

   function automatic logic [7:0] waddr(input logic [3:0] n);
      return 8'h40 + {2'h0, n, 2'h0};
   endfunction

   // returns {carry out, result}; byte ops keep the source upper byte
   function automatic logic [16:0] rot_exp(input logic [15:0] v, input logic bop,
                                           input logic thru, input logic cin);
      if (bop) begin
         return {thru ? v[7] : cin, v[15:8], v[6:0], thru ? cin : v[7]};
      end
      return {thru ? v[15] : cin, v[14:0], thru ? cin : v[15]};
   endfunction

   function automatic logic [31:0] st_exp(input logic [15:0] st, input logic [16:0] rc,
                                          input logic bop, input logic thru);
      logic [15:0] s;
      s = st;
      s[FLAG_N] = bop ? rc[7] : rc[15];
      s[FLAG_Z] = bop ? (rc[7:0] == 8'h00) : (rc[15:0] == 16'h0000);
      if (thru) begin
         s[FLAG_C] = rc[16];
      end
      return {16'h0000, s};
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      logic [15:0] v;
      logic [15:0] st;
      logic [15:0] w0;
      logic [16:0] rc;
      logic        thru;
      logic        bop;
      logic        dsel;
      logic        to_w;
      logic [12:0] f;
      seed = 58;
      fail_count = 0;
      total_checks = 0;
      rstn = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      wb(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
      chk(q, {16'h0000, STATUS_RST});
      wb(1'b0, OFS_INSTR, 32'h0, 4'hF, q);
      chk(q, {8'h00, INSTR_RST});
      wb(1'b0, 8'h30, 32'h0, 4'hF, q);
      chk(q, 32'h0000_0000);
      wb(1'b1, waddr(4'h1), 32'hFFFF_FFFF, 4'h1, q);
      wb(1'b0, waddr(4'h1), 32'h0, 4'hF, q);
      chk(q, 32'h0000_00FF);
      w0 = 16'h0000;
      // file forms: random with zero-result and msb corners first
      for (int i = 0; i < 64; i++) begin
         {thru, bop, dsel} = 3'($random(seed));
         f = 13'($random(seed));
         v = 16'($random(seed));
         st = 16'($random(seed));
         if (i < 3) begin
            v = (i == 0) ? 16'h0000 : ((i == 1) ? 16'h8000 : 16'hFF80);
            st[FLAG_C] = 1'b0;
         end
         to_w = thru ? dsel : ~dsel;
         wr(OFS_OPERAND, {16'h0000, v});
         wr(OFS_STATUS, {16'h0000, st});
         wr(OFS_INSTR, {8'h00, OPC_FILE, thru, bop, dsel, f});
         rc = rot_exp(v, bop, thru, st[FLAG_C]);
         wb(1'b0, OFS_RESULT, 32'h0, 4'hF, q);
         chk(q, {16'h0000, rc[15:0]});
         wb(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
         chk(q, st_exp(st, rc, bop, thru));
         wb(1'b0, OFS_INFO, 32'h0, 4'hF, q);
         chk(q, {27'h0, bop, ~to_w, to_w, 1'b0, 1'b1});
         wb(1'b0, OFS_ADDR, 32'h0, 4'hF, q);
         chk(q, {3'h0, f, 3'h0, f});
         if (to_w) begin
            w0 = bop ? {w0[15:8], rc[7:0]} : rc[15:0];
         end
         wb(1'b0, waddr(WORK_ZERO), 32'h0, 4'hF, q);
         chk(q, {16'h0000, w0});
      end
      // register form, direct to direct, all four carry and width mixes
      for (int i = 0; i < 4; i++) begin
         thru = i[0];
         bop = i[1];
         v = 16'($random(seed));
         st = 16'($random(seed));
         wr(waddr(4'h2), {16'h0000, v});
         wr(waddr(4'h5), 32'h0000_A5A5);
         wr(OFS_STATUS, {16'h0000, st});
         wr(OFS_INSTR, {8'h00, OPC_REG, thru, bop, AM_DIR, 4'h5, AM_DIR, 4'h2});
         rc = rot_exp(v, bop, thru, st[FLAG_C]);
         wb(1'b0, waddr(4'h5), 32'h0, 4'hF, q);
         chk(q, {16'h0000, bop ? {8'hA5, rc[7:0]} : rc[15:0]});
         wb(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
         chk(q, st_exp(st, rc, bop, thru));
      end
      // post-increment source: value comes through the operand port
      wr(waddr(4'h4), 32'h0000_2008);
      wr(OFS_OPERAND, 32'h0000_C041);
      wr(OFS_STATUS, 32'h0000_0001);
      wr(OFS_INSTR, {8'h00, OPC_REG, 1'b1, 1'b0, AM_DIR, 4'h8, AM_PINC, 4'h4});
      wb(1'b0, waddr(4'h8), 32'h0, 4'hF, q);
      chk(q, 32'h0000_8083);
      wb(1'b0, waddr(4'h4), 32'h0, 4'hF, q);
      chk(q, 32'h0000_200A);
      wb(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
      chk(q, 32'h0000_0009);
      // byte no-carry with pre-dec source and pre-inc destination, then post-dec and indirect
      wr(waddr(4'h6), 32'h0000_1000);
      wr(waddr(4'h7), 32'h0000_3000);
      wr(OFS_OPERAND, 32'h0000_00C3);
      wr(OFS_STATUS, 32'h0000_0000);
      wr(OFS_INSTR, {8'h00, OPC_REG, 1'b0, 1'b1, AM_RINC, 4'h7, AM_RDEC, 4'h6});
      wb(1'b0, OFS_RESULT, 32'h0, 4'hF, q);
      chk(q, 32'h0000_0087);
      wb(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
      chk(q, 32'h0000_0008);
      wb(1'b0, OFS_ADDR, 32'h0, 4'hF, q);
      chk(q, 32'h0FFF_3001);
      wb(1'b0, OFS_INFO, 32'h0, 4'hF, q);
      chk(q, 32'h0000_0019);
      wr(OFS_INSTR, {8'h00, OPC_REG, 1'b1, 1'b0, 3'h1, 4'h7, AM_PDEC, 4'h6});
      wb(1'b0, OFS_RESULT, 32'h0, 4'hF, q);
      chk(q, 32'h0000_0186);
      wb(1'b0, OFS_ADDR, 32'h0, 4'hF, q);
      chk(q, 32'h0FFF_3001);
      wb(1'b0, waddr(4'h6), 32'h0, 4'hF, q);
      chk(q, 32'h0000_0FFD);
      // foreign opcode and a reserved mode leave status alone
      for (int i = 0; i < 2; i++) begin
         wr(OFS_STATUS, 32'h0000_0005);
         wr(OFS_INSTR, (i == 0) ? 32'h00D7_8000 : {8'h00, OPC_REG, 1'b1, 1'b0, 3'h6, 4'h1, AM_DIR, 4'h2});
         wb(1'b0, OFS_INFO, 32'h0, 4'hF, q);
         chk(q, 32'h0000_0002);
         wb(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
         chk(q, 32'h0000_0005);
      end
      close_out();
   end
endmodule
`default_nettype wire
